// ===== rtl/tmr3_core.sv
// Purpose: 16-bit / split 8-bit auto-reload timer with capture mode
// Assumes: Classic Wishbone slave, 32-bit data, byte address on wb_adr_i
// Notes:   Registers sit at byte address four times their index
`timescale 1ns/1ps
`include "tmr3_params.svh"

// Notes on behaviour
// - High byte rollover sets high overflow flag
// - 16-bit wrap sets high overflow flag
// - Enabled high flag requests interrupt; software clears
// - Low byte rollover always sets low flag
// - Low enable adds low flag to request
// - Bit 4 switches capture mode
// - Bit 3 selects 16-bit or split
// - Run bit starts and stops counting
// - Split mode: run gates high byte only
// - Control bit 1 reads zero
// - External select: system/12 or external/8
// - External select applies to both bytes
// - Capture snapshots let software measure oscillator
// - 16-bit wrap loads reload value
// - Capture edge copies count, sets flag
// - Split bytes reload from own byte
// - Fast select uses undivided system clock
module tmr3_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_osc_div8_i,
  input  wire logic        timer_irq_enable_i,
  output logic             irq_request_o
);
  tmr3_pkg::tmr3_byte_t ctrl_r;
  tmr3_pkg::tmr3_byte_t ctrl_nxt;
  tmr3_pkg::tmr3_byte_t rll_r;
  tmr3_pkg::tmr3_byte_t rll_nxt;
  tmr3_pkg::tmr3_byte_t rlh_r;
  tmr3_pkg::tmr3_byte_t rlh_nxt;
  logic [15:0]          cnt_r;
  logic [15:0]          cnt_nxt;
  logic [1:0]           cksel_r;
  logic [1:0]           cksel_nxt;
  logic                 ack_r;
  logic                 ack_nxt;
  logic [31:0]          dat_r;
  logic [31:0]          dat_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 hit;
  logic                 wr;
  logic [9:0]           idx;
  logic                 we_ctrl;
  logic                 we_rll;
  logic                 we_rlh;
  logic                 we_cntl;
  logic                 we_cnth;
  logic                 we_cksel;
  logic                 we_any;
  tmr3_pkg::tmr3_mode_t mode;
  logic                 run;
  logic                 lo_en;
  logic                 hi_en;
  logic                 hset;
  logic                 lset;

  tmr3_tick_if tk ();

  tmr3_tick_gen u_tick (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ext_osc_div8_i (ext_osc_div8_i),
    .tk             (tk)
  );

  assign tk.ext_sel    = ctrl_r[`TMR3_B_XCLK];
  assign tk.capture_en = ctrl_r[`TMR3_B_CAPEN];
  assign tk.fast_lo    = cksel_r[`TMR3_B_FAST_LO];
  assign tk.fast_hi    = cksel_r[`TMR3_B_FAST_HI];

  // Bus decode; a write lands on the edge where ack is seen
  assign hit      = wb_cyc_i & wb_stb_i;
  assign idx      = wb_adr_i[11:2];
  assign wr       = hit & wb_we_i & ack_r & wb_sel_i[0];
  assign we_ctrl  = wr & (idx == `TMR3_IDX_CTRL);
  assign we_rll   = wr & (idx == `TMR3_IDX_RLL);
  assign we_rlh   = wr & (idx == `TMR3_IDX_RLH);
  assign we_cntl  = wr & (idx == `TMR3_IDX_CNTL);
  assign we_cnth  = wr & (idx == `TMR3_IDX_CNTH);
  assign we_cksel = wr & (idx == `TMR3_IDX_CKSEL);
  assign we_any   = we_ctrl | we_rll | we_rlh | we_cntl | we_cnth;

  assign mode  = tmr3_pkg::tmr3_mode_t'(ctrl_r[`TMR3_B_SPLIT]);
  assign run   = ctrl_r[`TMR3_B_RUN];
  // Low byte runs free in split mode
  assign lo_en = tk.low_tick &
                 (run | (mode == tmr3_pkg::TMR3_MODE_SPLIT));
  assign hi_en = tk.high_tick & run;

  // Counter, reload and flag updates
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    rll_nxt   = rll_r;
    rlh_nxt   = rlh_r;
    cnt_nxt   = cnt_r;
    cksel_nxt = cksel_r;
    hset      = 1'b0;
    lset      = 1'b0;
    unique case (mode)
      tmr3_pkg::TMR3_MODE_16:
      begin
        if (lo_en)
        begin
          lset = (cnt_r[7:0] == 8'hff);
          if (cnt_r == 16'hffff)
          begin
            cnt_nxt = {rlh_r, rll_r};
            hset    = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
      end
      tmr3_pkg::TMR3_MODE_SPLIT:
      begin
        if (lo_en)
        begin
          lset = (cnt_r[7:0] == 8'hff);
          cnt_nxt[7:0] = lset ? rll_r : cnt_r[7:0] + 8'h01;
        end
        if (hi_en)
        begin
          hset = (cnt_r[15:8] == 8'hff);
          cnt_nxt[15:8] = hset ? rlh_r
                               : cnt_r[15:8] + 8'h01;
        end
      end
    endcase
    // Snapshot for frequency measurement
    if (tk.capture_evt)
    begin
      {rlh_nxt, rll_nxt} = cnt_r;
      hset = 1'b1;
    end
    if (we_rll)
    begin
      rll_nxt = wb_dat_i[7:0];
    end
    if (we_rlh)
    begin
      rlh_nxt = wb_dat_i[7:0];
    end
    if (we_cntl)
    begin
      cnt_nxt[7:0] = wb_dat_i[7:0];
    end
    if (we_cnth)
    begin
      cnt_nxt[15:8] = wb_dat_i[7:0];
    end
    if (we_cksel)
    begin
      cksel_nxt = wb_dat_i[1:0];
    end
    if (we_ctrl)
    begin
      ctrl_nxt = wb_dat_i[7:0] & `TMR3_CTRL_WMASK;
    end
    // Hardware set wins over a software clear
    ctrl_nxt[`TMR3_B_HOVF] = ctrl_nxt[`TMR3_B_HOVF] | hset;
    ctrl_nxt[`TMR3_B_LOVF] = ctrl_nxt[`TMR3_B_LOVF] | lset;
    irq_nxt = timer_irq_enable_i & (ctrl_r[`TMR3_B_HOVF] |
              (ctrl_r[`TMR3_B_LIEN] & ctrl_r[`TMR3_B_LOVF]));
  end

  // Bus answer: ack one cycle after the request, dropped the next
  always_comb
  begin
    ack_nxt = hit & ~ack_r;
    dat_nxt = 32'h0000_0000;
    if (hit & ~ack_r & ~wb_we_i)
    begin
      unique case (idx)
        `TMR3_IDX_CTRL:  dat_nxt[7:0] = ctrl_r;
        `TMR3_IDX_RLL:   dat_nxt[7:0] = rll_r;
        `TMR3_IDX_RLH:   dat_nxt[7:0] = rlh_r;
        `TMR3_IDX_CNTL:  dat_nxt[7:0] = cnt_r[7:0];
        `TMR3_IDX_CNTH:  dat_nxt[7:0] = cnt_r[15:8];
        `TMR3_IDX_CKSEL: dat_nxt[1:0] = cksel_r;
        default:         dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r  <= `TMR3_CTRL_RST;
      rll_r   <= `TMR3_BYTE_RST;
      rlh_r   <= `TMR3_BYTE_RST;
      cnt_r   <= `TMR3_CNT_RST;
      cksel_r <= `TMR3_CKSEL_RST;
      ack_r   <= 1'b0;
      dat_r   <= 32'h0000_0000;
      irq_r   <= 1'b0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      rll_r   <= rll_nxt;
      rlh_r   <= rlh_nxt;
      cnt_r   <= cnt_nxt;
      cksel_r <= cksel_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign irq_request_o = irq_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wrap16_s;
    mode == tmr3_pkg::TMR3_MODE_16 && lo_en && cnt_r == 16'hffff
      && !we_any && !tk.capture_evt;
  endsequence
  sequence hi_roll_s;
    mode == tmr3_pkg::TMR3_MODE_SPLIT && hi_en && cnt_r[15:8] == 8'hff
      && !we_cnth;
  endsequence
  sequence lo_roll_s;
    lo_en && cnt_r[7:0] == 8'hff && !we_cntl;
  endsequence
  // Count steps by one between wraps
  sequence count16_s;
    mode == tmr3_pkg::TMR3_MODE_16 && lo_en && cnt_r != 16'hffff
      && !we_cntl && !we_cnth;
  endsequence

  wrap_reload_a: assert property (wrap16_s |=>
    cnt_r == {$past(rlh_r), $past(rll_r)})
    else $error("16-bit wrap did not load reload value");
  wrap_flag_a: assert property (wrap16_s |=> ctrl_r[7])
    else $error("16-bit wrap did not set high flag");
  hi_roll_a: assert property (hi_roll_s |=>
    ctrl_r[7] && cnt_r[15:8] == $past(rlh_r))
    else $error("High byte rollover missed flag or reload");
  lo_roll_a: assert property (lo_roll_s |=> ctrl_r[6])
    else $error("Low byte rollover did not set low flag");
  split_lo_a: assert property ((lo_roll_s and
    (mode == tmr3_pkg::TMR3_MODE_SPLIT)) |=> cnt_r[7:0] == $past(rll_r))
    else $error("Split low byte did not reload");
  flag_hold_a: assert property (ctrl_r[7] && !we_ctrl |=> ctrl_r[7])
    else $error("High flag cleared without software");
  irq_high_a: assert property (timer_irq_enable_i && ctrl_r[7]
    |=> irq_request_o)
    else $error("High flag did not raise request");
  irq_low_a: assert property (timer_irq_enable_i && ctrl_r[5]
    && ctrl_r[6] |=> irq_request_o)
    else $error("Low flag did not raise request");
  irq_off_a: assert property (!timer_irq_enable_i |=> !irq_request_o)
    else $error("Request raised while disabled");
  stopped_a: assert property (mode == tmr3_pkg::TMR3_MODE_16 && !run
    && !we_cntl && !we_cnth |=> $stable(cnt_r))
    else $error("Stopped timer changed");
  split_free_a: assert property (mode == tmr3_pkg::TMR3_MODE_SPLIT
    && !run && tk.low_tick && !we_cntl && cnt_r[7:0] != 8'hff
    |=> cnt_r[7:0] == $past(cnt_r[7:0]) + 8'h01)
    else $error("Split low byte not free running");
  bit1_zero_a: assert property (ctrl_r[1] == 1'b0)
    else $error("Control bit 1 not zero");
  capture_a: assert property (tk.capture_evt && !we_rll && !we_rlh
    |=> {rlh_r, rll_r} == $past(cnt_r) && ctrl_r[7])
    else $error("Capture did not snapshot count");
  count16_a: assert property (count16_s |=>
    cnt_r == $past(cnt_r) + 16'h0001)
    else $error("Running 16-bit count did not step");
  split_hold_a: assert property (mode == tmr3_pkg::TMR3_MODE_SPLIT
    && !run && !we_cnth |=> $stable(cnt_r[15:8]))
    else $error("Stopped split high byte changed");
  set_wins_a: assert property (hset && we_ctrl |=> ctrl_r[7])
    else $error("Software clear beat a high overflow");
  ctrl_wr_a: assert property (we_ctrl |=>
    ctrl_r[5:2] == $past(wb_dat_i[5:2]))
    else $error("Control write did not land");
  ack_pulse_a: assert property (hit && !ack_r |=> ack_r ##1 !ack_r)
    else $error("Bus ack not a single cycle");
endmodule

// ===== rtl/tmr3_params.svh
// Purpose: Offsets, bit positions, reset values and counts of the timer
// Assumes: Word index times four is the byte address on the bus
// Notes:   Definitions only
`ifndef TMR3_PARAMS_SVH
`define TMR3_PARAMS_SVH

// Register indices
`define TMR3_IDX_CTRL   10'h091
`define TMR3_IDX_RLL    10'h092
`define TMR3_IDX_RLH    10'h093
`define TMR3_IDX_CNTL   10'h094
`define TMR3_IDX_CNTH   10'h095
`define TMR3_IDX_CKSEL  10'h096

// Control register bit positions
`define TMR3_B_HOVF     7
`define TMR3_B_LOVF     6
`define TMR3_B_LIEN     5
`define TMR3_B_CAPEN    4
`define TMR3_B_SPLIT    3
`define TMR3_B_RUN      2
`define TMR3_B_XCLK     0
`define TMR3_CTRL_WMASK 8'hfd

// Clock select register bit positions
`define TMR3_B_FAST_LO  0
`define TMR3_B_FAST_HI  1

// Reset values
`define TMR3_CTRL_RST   8'h00
`define TMR3_BYTE_RST   8'h00
`define TMR3_CNT_RST    16'h0000
`define TMR3_CKSEL_RST  2'h0

// System clock prescaler: one tick every 12 cycles
`define TMR3_DIV_LAST   4'hb
`define TMR3_DIV_RST    4'h0
`define TMR3_SYNC_RST   3'h0

`endif

// ===== rtl/tmr3_pkg.sv
// Purpose: Types shared by the timer files
// Assumes: Constants live in tmr3_params.svh
// Notes:   Nothing here is imported
package tmr3_pkg;
  typedef logic [7:0] tmr3_byte_t;
  typedef enum logic {
    TMR3_MODE_16    = 1'b0,
    TMR3_MODE_SPLIT = 1'b1
  } tmr3_mode_t;
endpackage

// ===== rtl/tmr3_tick_if.sv
// Purpose: Clock-select controls and count enables between timer modules
// Assumes: Single clock domain
// Notes:   Ticks are one-cycle pulses, except that fast select holds low_tick or high_tick high every cycle
`timescale 1ns/1ps
interface tmr3_tick_if;
  logic ext_sel;
  logic capture_en;
  logic fast_lo;
  logic fast_hi;
  logic low_tick;
  logic high_tick;
  logic capture_evt;
  modport gen  (input  ext_sel, capture_en, fast_lo, fast_hi,
                output low_tick, high_tick, capture_evt);
  modport core (output ext_sel, capture_en, fast_lo, fast_hi,
                input  low_tick, high_tick, capture_evt);
endinterface

// ===== rtl/tmr3_tick_gen.sv
// Purpose: Count enables from system clock, its /12 tick or external /8
// Assumes: ext_osc_div8_i is asynchronous and slower than clk_i / 2
// Notes:   Three-stage chain; edges found between stages two and three
`timescale 1ns/1ps
`include "tmr3_params.svh"
module tmr3_tick_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ext_osc_div8_i,
  tmr3_tick_if.gen  tk
);
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       sys_tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       base_tick;

  always_comb
  begin
    div_nxt  = (div_r == `TMR3_DIV_LAST) ? `TMR3_DIV_RST
                                         : div_r + 4'h1;
    sync_nxt = {sync_r[1:0], ext_osc_div8_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_r  <= `TMR3_DIV_RST;
      sync_r <= `TMR3_SYNC_RST;
    end
    else
    begin
      div_r  <= div_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sys_tick  = (div_r == `TMR3_DIV_LAST);
  assign ext_rise  = sync_r[1] & ~sync_r[2];
  assign ext_fall  = ~sync_r[1] & sync_r[2];
  // External source counts only outside capture mode
  assign base_tick = (tk.ext_sel & ~tk.capture_en) ? ext_rise
                                                   : sys_tick;
  assign tk.low_tick    = tk.fast_lo | base_tick;
  assign tk.high_tick   = tk.fast_hi | base_tick;
  assign tk.capture_evt = tk.capture_en & ext_fall;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  div12_gap_a: assert property (sys_tick |=> (!sys_tick)[*8] ##1
    (!sys_tick)[*3] ##1 sys_tick)
    else $error("System tick spacing is not 12 cycles");
  ext_sel_a: assert property (tk.ext_sel && !tk.capture_en
    && !tk.fast_lo |-> tk.low_tick == ext_rise)
    else $error("External select does not drive the low tick");
  fast_sel_a: assert property (tk.fast_hi |-> tk.high_tick)
    else $error("Fast select does not tick every cycle");
  cap_pulse_a: assert property (tk.capture_evt |=> !tk.capture_evt)
    else $error("Capture event longer than one cycle");
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the timer control and capture block
// Assumes: Registers reached over classic Wishbone at four times index
// Notes:   Seeded random reload values among directed cases
`timescale 1ns/1ps
`include "tmr3_params.svh"
module testbench;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0]  wb_sel = 4'h1;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ext_osc = 1'b0;
  logic        tmr_en  = 1'b0;
  logic        irq_o;
  logic        ext_on  = 1'b0;
  logic [4:0]  ph      = 5'h00;
  logic [7:0]  rdat;
  logic [7:0]  c;
  logic [7:0]  a;
  logic [31:0] r;
  integer      seed = 32'hc690;
  integer      failures = 0;
  integer      checks_done = 0;

  always #5 clk_i = ~clk_i;

  // External source: period of 20 system clocks while enabled
  always @(posedge clk_i)
  begin
    if (ext_on)
    begin
      ph <= (ph == 5'h09) ? 5'h00 : ph + 5'h01;
      if (ph == 5'h09)
        ext_osc <= ~ext_osc;
    end
  end

  tmr3_core uut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc),
    .wb_stb_i           (wb_stb),
    .wb_we_i            (wb_we),
    .wb_adr_i           (wb_adr),
    .wb_sel_i           (wb_sel),
    .wb_dat_i           (wb_dat),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .ext_osc_div8_i     (ext_osc),
    .timer_irq_enable_i (tmr_en),
    .irq_request_o      (irq_o)
  );

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] inr(input logic [7:0] v, lo, hi);
    return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
  endfunction

  // Bounded wait for ack; read data taken at the ack edge
  task automatic wt;
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    while (!got && n < 20)
    begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
      rdat = wb_dat_o[7:0];
      n++;
    end
    if (!got)
    begin
      failures++;
      results();
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= 3'b111;
    wb_adr <= {i, 2'h0};
    wb_dat <= {24'h0, d};
    wt();
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask

  task automatic rd(input logic [9:0] i, output logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= 3'b110;
    wb_adr <= {i, 2'h0};
    wt();
    d = rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask

  task automatic wait_hflag;
    int n;
    c = 8'h00;
    for (n = 0; n < 60 && c[7] !== 1'b1; n++)
      rd(`TMR3_IDX_CTRL, c);
    chk(c & 8'h80, 8'h80);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(10'(`TMR3_IDX_CTRL + i), c);
      chk(c, 8'h00);
    end
    wr(10'h0a0, 8'hff);
    rd(10'h0a0, c);
    chk(c, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      wr(`TMR3_IDX_RLL, r[7:0]);
      wr(`TMR3_IDX_RLH, r[15:8]);
      rd(`TMR3_IDX_RLL, c);
      chk(c, r[7:0]);
      rd(`TMR3_IDX_RLH, c);
      chk(c, r[15:8]);
    end
    // Write with the low byte lane off is acked and ignored
    wb_sel <= 4'h0;
    wr(`TMR3_IDX_RLL, ~r[7:0]);
    wb_sel <= 4'h1;
    rd(`TMR3_IDX_RLL, c);
    chk(c, r[7:0]);
    // Control bits and interrupt gating
    wr(`TMR3_IDX_CTRL, 8'hfe);
    rd(`TMR3_IDX_CTRL, c);
    chk(c, 8'hfe & `TMR3_CTRL_WMASK);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    tmr_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    wr(`TMR3_IDX_CTRL, 8'h40);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    wr(`TMR3_IDX_CTRL, 8'h60);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    wr(`TMR3_IDX_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    // 16-bit wrap and reload
    wr(`TMR3_IDX_CKSEL, 8'h03);
    wr(`TMR3_IDX_RLL, 8'h00);
    wr(`TMR3_IDX_RLH, 8'h12);
    wr(`TMR3_IDX_CNTL, 8'hf0);
    wr(`TMR3_IDX_CNTH, 8'hff);
    wr(`TMR3_IDX_CTRL, 8'h04);
    repeat (30) @(posedge clk_i);
    rd(`TMR3_IDX_CTRL, c);
    chk(c, 8'hc4);
    wr(`TMR3_IDX_CTRL, 8'hc0);
    rd(`TMR3_IDX_CNTH, c);
    chk(c, 8'h12);
    rd(`TMR3_IDX_CNTL, a);
    repeat (10) @(posedge clk_i);
    rd(`TMR3_IDX_CNTL, c);
    chk(c, a);
    // Split mode: low byte free running, high byte gated
    wr(`TMR3_IDX_CTRL, 8'h00);
    wr(`TMR3_IDX_RLL, 8'h10);
    wr(`TMR3_IDX_CNTL, 8'hf0);
    wr(`TMR3_IDX_CNTH, 8'h80);
    wr(`TMR3_IDX_CTRL, 8'h08);
    repeat (40) @(posedge clk_i);
    rd(`TMR3_IDX_CTRL, c);
    chk(c, 8'h48);
    rd(`TMR3_IDX_CNTH, c);
    chk(c, 8'h80);
    rd(`TMR3_IDX_CNTL, c);
    chk(inr(c, 8'h10, 8'h60), 8'h01);
    wr(`TMR3_IDX_CTRL, 8'h0c);
    repeat (150) @(posedge clk_i);
    rd(`TMR3_IDX_CTRL, c);
    chk(c & 8'h80, 8'h80);
    rd(`TMR3_IDX_CNTH, c);
    chk(inr(c, 8'h12, 8'h40), 8'h01);
    // Rate of the divided system clock and the external source
    wr(`TMR3_IDX_CTRL, 8'h00);
    wr(`TMR3_IDX_CKSEL, 8'h00);
    wr(`TMR3_IDX_CNTL, 8'h00);
    wr(`TMR3_IDX_CNTH, 8'h00);
    wr(`TMR3_IDX_CTRL, 8'h04);
    repeat (240) @(posedge clk_i);
    rd(`TMR3_IDX_CNTL, c);
    chk(inr(c, 8'd18, 8'd23), 8'h01);
    wr(`TMR3_IDX_CTRL, 8'h00);
    wr(`TMR3_IDX_CNTL, 8'h00);
    ext_on <= 1'b1;
    wr(`TMR3_IDX_CTRL, 8'h05);
    repeat (400) @(posedge clk_i);
    rd(`TMR3_IDX_CNTL, c);
    chk(inr(c, 8'd18, 8'd23), 8'h01);
    rd(`TMR3_IDX_RLL, c);
    chk(c, 8'h10);
    // Capture: successive snapshots differ by the source period
    wr(`TMR3_IDX_CTRL, 8'h00);
    wr(`TMR3_IDX_CKSEL, 8'h01);
    wr(`TMR3_IDX_CTRL, 8'h14);
    wait_hflag();
    rd(`TMR3_IDX_RLL, a);
    wr(`TMR3_IDX_CTRL, 8'h14);
    wait_hflag();
    rd(`TMR3_IDX_RLL, c);
    chk(c - a, 8'd20);
    results();
  end
endmodule
